// ===== rtl/jtp_tap.sv
// Test access port controller with instruction, bypass, identification and user registers
`timescale 1ns/1ns
module jtp_tap
  import jtp_pkg::*;
#(
  parameter logic [jtp_pkg::DR_W-1:0] IDCODE = jtp_pkg::IDCODE_DEFAULT
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    tck_pin,
  input  wire logic                    tms_pin,
  input  wire logic                    tdi_pin,
  input  wire logic                    trst_pin,
  output logic                         tdo_out,
  output logic                         tdo_oe,
  output logic                         scan_control,
  output logic [jtp_pkg::DR_W-1:0]     user_data,
  output logic                         user_update
);
  import jtp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_sync;
  logic              tck_s;
  logic              tms_s;
  logic              tdi_s;
  logic              trst_s;

  jtp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({trst_pin, tdi_pin, tms_pin, tck_pin}),
    .dout    (pins_sync)
  );

  // Unpack synchronised pins
  assign tck_s  = pins_sync[0];
  assign tms_s  = pins_sync[1];
  assign tdi_s  = pins_sync[2];
  assign trst_s = pins_sync[3];

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    jtp_state_t      tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic [DR_W-1:0] dr_sh;
    logic [DR_W-1:0] user;
    logic            user_upd;
    logic            tck_prev;
    logic            tdo;
    logic            oe;
    logic            scan;
  } jtp_regs_t;

  jtp_regs_t r;
  jtp_regs_t next_r;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Standard sixteen-state transition on the sampled mode select
  function automatic jtp_state_t tap_step(input jtp_state_t s, input logic tms);
    jtp_state_t n;
    n = ST_RESET;
    case (s)
      ST_RESET:    n = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     n = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   n = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   n = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   n = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   n = tms ? ST_SEL_DR   : ST_IDLE;
      default:     n = ST_RESET;
    endcase
    return n;
  endfunction : tap_step

  // Instructions with a full-width data path; anything else is bypass
  function automatic logic wide_dr(input logic [IR_W-1:0] ins);
    return (ins == INS_IDCODE) || (ins == INS_USER);
  endfunction : wide_dr

  // ----------------------------------------------------------------
  // Edge detection on the sampled test clock
  // ----------------------------------------------------------------
  logic tck_rise;
  logic tck_fall;

  // Edges are seen a few system cycles late; test clock must be well below clk_sys
  assign tck_rise = tck_s & ~r.tck_prev;
  assign tck_fall = ~tck_s & r.tck_prev;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.tck_prev = tck_s;
    next_r.user_upd = 1'b0;
    next_r.scan     = trst_s;
    if (!trst_s) begin
      // Functional mode: controller held in reset, other pins ignored
      next_r.tap = ST_RESET;
      next_r.ir  = IR_RESET_VAL;
      next_r.oe  = 1'b0;
      next_r.tdo = 1'b0;
    end else begin
      if (tck_rise) begin
        next_r.tap = tap_step(r.tap, tms_s);
        case (r.tap)
          ST_RESET: begin
            next_r.ir = IR_RESET_VAL;
          end
          ST_CAP_IR: begin
            next_r.ir_sh = IR_CAPTURE_VAL;
          end
          ST_SHIFT_IR: begin
            next_r.ir_sh = {tdi_s, r.ir_sh[IR_W-1:1]};
          end
          ST_UPD_IR: begin
            next_r.ir = r.ir_sh;
          end
          ST_CAP_DR: begin
            if (r.ir == INS_IDCODE) begin
              next_r.dr_sh = IDCODE;
            end else if (r.ir == INS_USER) begin
              next_r.dr_sh = r.user;
            end else begin
              next_r.dr_sh = DR_RESET_VAL;
            end
          end
          ST_SHIFT_DR: begin
            if (wide_dr(r.ir)) begin
              next_r.dr_sh = {tdi_s, r.dr_sh[DR_W-1:1]};
            end else begin
              next_r.dr_sh[0] = tdi_s;
            end
          end
          ST_UPD_DR: begin
            if (r.ir == INS_USER) begin
              next_r.user     = r.dr_sh;
              next_r.user_upd = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      if (tck_fall) begin
        // Output lane only moves on the falling edge
        case (r.tap)
          ST_SHIFT_IR: begin
            next_r.tdo = r.ir_sh[0];
            next_r.oe  = 1'b1;
          end
          ST_SHIFT_DR: begin
            next_r.tdo = r.dr_sh[0];
            next_r.oe  = 1'b1;
          end
          default: begin
            next_r.oe = 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r.tap      <= ST_RESET;
      r.ir       <= IR_RESET_VAL;
      r.ir_sh    <= IR_RESET_VAL;
      r.dr_sh    <= DR_RESET_VAL;
      r.user     <= USER_RESET_VAL;
      r.user_upd <= 1'b0;
      r.tck_prev <= 1'b0;
      r.tdo      <= 1'b0;
      r.oe       <= 1'b0;
      r.scan     <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign tdo_out      = r.tdo;
  assign tdo_oe       = r.oe;
  assign scan_control = r.scan;
  assign user_data    = r.user;
  assign user_update  = r.user_upd;

endmodule : jtp_tap

// ===== shared/jtp_pkg.sv
// Package for the test access port: widths, instruction codes, states and reset values
package jtp_pkg;

  // ----------------------------------------------------------------
  // Register widths
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int SYNC_W = 4;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET_VAL   = 4'h1;
  localparam logic [IR_W-1:0] INS_IDCODE     = 4'h1;
  localparam logic [IR_W-1:0] INS_USER       = 4'h8;
  localparam logic [IR_W-1:0] INS_BYPASS     = 4'hf;

  // Identification word, value is arbitrary
  localparam logic [DR_W-1:0] IDCODE_DEFAULT = 32'h0a5c_3e01;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DR_W-1:0] DR_RESET_VAL   = 32'h0000_0000;
  localparam logic [DR_W-1:0] USER_RESET_VAL = 32'h0000_0000;
  localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 4'h0;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET     = 4'b0000,
    ST_IDLE      = 4'b0001,
    ST_SEL_DR    = 4'b0010,
    ST_CAP_DR    = 4'b0011,
    ST_SHIFT_DR  = 4'b0100,
    ST_EXIT1_DR  = 4'b0101,
    ST_PAUSE_DR  = 4'b0110,
    ST_EXIT2_DR  = 4'b0111,
    ST_UPD_DR    = 4'b1000,
    ST_SEL_IR    = 4'b1001,
    ST_CAP_IR    = 4'b1010,
    ST_SHIFT_IR  = 4'b1011,
    ST_EXIT1_IR  = 4'b1100,
    ST_PAUSE_IR  = 4'b1101,
    ST_EXIT2_IR  = 4'b1110,
    ST_UPD_IR    = 4'b1111
  } jtp_state_t;

endpackage : jtp_pkg

// ===== rtl/jtp_sync.sv
// Two-stage synchroniser for the test pins
`timescale 1ns/1ns
module jtp_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : jtp_sync

// ===== dv/jtp_tap_asserts.sv
// Pin-level checks on the test access port
`timescale 1ns/1ns
module jtp_tap_asserts
  import jtp_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  tck_pin,
  input wire logic                  trst_pin,
  input wire logic                  tdo_out,
  input wire logic                  tdo_oe,
  input wire logic                  scan_control,
  input wire logic [jtp_pkg::DR_W-1:0] user_data,
  input wire logic                  user_update
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Age of test reset high; pin edges only count once it settles
  logic [2:0] trst_age;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) trst_age <= 3'h0;
    else if (!trst_pin) trst_age <= 3'h0;
    else if (trst_age != 3'h7) trst_age <= trst_age + 3'h1;
  end
  // Pin fell 2 to 4 cycles ago
  sequence fall_seen;
    !tck_pin && !$past(tck_pin, 2) && $past(tck_pin, 5);
  endsequence
  // Pin rose within the last 6 cycles
  sequence rise_seen;
    tck_pin && !$past(tck_pin, 6);
  endsequence
  a_scan_follows_trst: assert property ($stable(trst_pin) [*5] |-> scan_control == trst_pin)
    else $error("scan control lags test reset");
  a_func_no_drive: assert property (!trst_pin [*5] |-> !tdo_oe)
    else $error("tdo driven in functional mode");
  a_func_no_update: assert property (user_update |-> scan_control)
    else $error("update outside scan control");
  a_tdo_on_fall: assert property (trst_age == 3'h7 && $changed(tdo_out) |-> fall_seen)
    else $error("tdo moved without falling test clock");
  a_oe_on_fall: assert property (trst_age == 3'h7 && $changed(tdo_oe) |-> fall_seen)
    else $error("tdo enable moved without falling test clock");
  a_update_on_rise: assert property (user_update |-> rise_seen)
    else $error("update not after rising test clock");
  a_update_pulse_once: assert property (user_update |=> !user_update)
    else $error("update pulse too long");
  a_data_on_update: assert property ($changed(user_data) |-> user_update)
    else $error("user data moved without update");
endmodule : jtp_tap_asserts

bind jtp_tap jtp_tap_asserts i_jtp_tap_asserts (.clk_sys(clk_sys), .rst(rst), .tck_pin(tck_pin),
  .trst_pin(trst_pin), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .scan_control(scan_control),
  .user_data(user_data), .user_update(user_update));

// ===== dv/jtp_probe.sv
// Behavioural debugger pod driving the test pins
`timescale 1ns/1ns
module jtp_probe (
  input  wire logic clk_sys,
  input  wire logic tdo_out,
  input  wire logic tdo_oe,
  output logic      tck_pin,
  output logic      tms_pin,
  output logic      tdi_pin,
  output logic      trst_pin
);
  // Functional use until the bench takes scan control
  initial begin
    tck_pin = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b1;
    trst_pin = 1'b0;
  end
  // Test reset change, then a settle time before any test clock
  task automatic set_trst(input logic v);
    @(posedge clk_sys);
    #1 trst_pin = v;
    repeat (8) @(posedge clk_sys);
  endtask : set_trst
  // Test clocks of 16 cycles; tdo read just before each rise
  task automatic walk(input logic [63:0] tms_v, input logic [63:0] tdi_v, input int n,
                      output logic [31:0] tdo_v);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_sys);
      #1 tms_pin = tms_v[i];
      tdi_pin = tdi_v[i];
      repeat (4) @(posedge clk_sys);
      // Released lane has no pull, so the pod sees the inverse of the last bit
      #1 if (i < 32) tdo_v[i] = tdo_oe ? tdo_out : ~tdo_out;
      tck_pin = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1 tck_pin = 1'b0;
    end
    tdi_pin = 1'b1; // Idle at pull-up level
  endtask : walk
endmodule : jtp_probe

// ===== dv/jtp_tap_tb.sv
// Self-checking bench for the test access port
`timescale 1ns/1ns
module jtp_tap_tb;
  import jtp_pkg::*;
  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  logic            tck_pin, tms_pin, tdi_pin, trst_pin, tdo_out, tdo_oe, scan_control, user_update;
  logic [DR_W-1:0] user_data, seen, rnd;
  logic [IR_W-1:0] ins;
  int              miscompares = 0, n_compared = 0, n_upd = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;

  jtp_tap i_jtp_tap (.clk_sys(clk_sys), .rst(rst), .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin),
    .trst_pin(trst_pin), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .scan_control(scan_control),
    .user_data(user_data), .user_update(user_update));
  jtp_probe i_jtp_probe (.clk_sys(clk_sys), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .tck_pin(tck_pin),
    .tms_pin(tms_pin), .tdi_pin(tdi_pin), .trst_pin(trst_pin));

  // Update pulse count and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (user_update === 1'b1) n_upd++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic check(input logic [DR_W-1:0] got, input logic [DR_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // One-bit bypass delays the stream by a leading zero
  function automatic logic [DR_W-1:0] exp_bypass(input logic [DR_W-1:0] d);
    return {d[DR_W-2:0], 1'b0};
  endfunction : exp_bypass

  // Idle, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input logic [DR_W-1:0] din, input int n, output logic [DR_W-1:0] dout);
    logic [DR_W-1:0] t;
    i_jtp_probe.walk(ir ? 64'h3 : 64'h1, '1, ir ? 4 : 3, t);
    i_jtp_probe.walk(64'h3 << (n - 1), {32'h0, din}, n + 1, dout);
    i_jtp_probe.walk(64'h0, '1, 1, t);
  endtask : scan

  // Main sequence
  initial begin
    void'($urandom(32'hf7f2));
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    rnd = $urandom();
    i_jtp_probe.walk({rnd, rnd}, {~rnd, rnd}, 32, seen);
    check(tdo_oe, 1'b0);
    check(n_upd, 0);
    check(scan_control, 1'b0);
    i_jtp_probe.set_trst(1'b1);
    check(scan_control, 1'b1);
    i_jtp_probe.walk(64'h1f, '1, 6, seen);
    scan(1'b0, rnd, 32, seen);
    check(seen, IDCODE_DEFAULT);
    scan(1'b1, {28'h0, INS_USER}, 4, seen);
    check({28'h0, seen[3:0]}, {28'h0, IR_CAPTURE_VAL});
    rnd = $urandom();
    scan(1'b0, rnd, 32, seen);
    check(seen, USER_RESET_VAL);
    check(user_data, rnd);
    check(n_upd, 1);
    for (int k = 0; k < 4; k++) begin
      ins = (k == 0) ? INS_BYPASS : IR_W'($urandom_range(2, 7));
      rnd = $urandom();
      scan(1'b1, {28'h0, ins}, 4, seen);
      scan(1'b0, rnd, 32, seen);
      check(seen, exp_bypass(rnd));
    end
    check(n_upd, 1);
    i_jtp_probe.walk(64'h1, '1, 7, seen);
    // Frame cut in mid shift: lane must be driven before test reset drops it
    repeat (6) @(posedge clk_sys);
    #1 check(tdo_oe, 1'b1);
    i_jtp_probe.set_trst(1'b0);
    check(tdo_oe, 1'b0);
    check(scan_control, 1'b0);
    i_jtp_probe.set_trst(1'b1);
    i_jtp_probe.walk(64'h0, '1, 1, seen);
    scan(1'b0, rnd, 32, seen);
    check(seen, IDCODE_DEFAULT);
    results();
  end
endmodule : jtp_tap_tb
